// [asp_host_model.sv]
// Host model for the serial side: drives load strobe and shift clock, gathers bits.
// Assumes i_clk is the 50 MHz system clock; a frame starts on a one-cycle i_start.
`timescale 1ns/10ps
module asp_host_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_noisy,
  input wire logic i_serial_out,
  output logic o_shift_clock,
  output logic o_parallel_load_n,
  output logic [11:0] o_word,
  output logic o_done
);
  int i;
  initial begin
    o_shift_clock = 1'b0;
    o_parallel_load_n = 1'b1;
    o_word = 12'h000;
    o_done = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_start) begin
      o_done <= 1'b0;
      o_parallel_load_n <= 1'b0;
      for (i = 0; i < 8; i++) begin
        @(posedge i_clk);
        // Stray shift edges while loading must be ignored
        if (i_noisy && i < 4) o_shift_clock <= ~o_shift_clock;
      end
      o_parallel_load_n <= 1'b1;
      for (i = 11; i >= 0; i--) begin
        repeat (4) @(posedge i_clk);
        o_word[i] <= i_serial_out;
        if (i > 0) o_shift_clock <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_shift_clock <= 1'b0;
      end
      o_done <= 1'b1;
    end
  end
endmodule

// [asp_pkg.sv]
// Package for the converter serial output port: widths, formats, register map.
// Assumes a single 50 MHz system clock domain.
package asp_pkg;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned MSB_POS = 11;
  localparam logic [3:0] BIT_COUNT_LAST = 4'hc;
  // Register map (word indices on the plain port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h5;
  // Control fields
  localparam int unsigned CTRL_MSB_INV_POS = 0;
  localparam int unsigned CTRL_LSB_INV_POS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Interrupt event bits
  localparam int unsigned IRQ_LOAD_POS = 0;
  localparam int unsigned IRQ_DONE_POS = 1;
  localparam int unsigned IRQ_UNDER_POS = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_EMPTY = 2'b11
  } asp_state_type;
endpackage

// [asp_serial_port.sv]
// Serial output port of a 12-bit sampling converter: format, load, shift.
// Assumes conversion results arrive on i_clk; shift clock and load are pins.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module asp_serial_port (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_conv_clk,
  input wire logic i_track_hold,
  input wire logic [asp_pkg::RESULT_W-1:0] i_raw_result,
  input wire logic i_below_range,
  input wire logic i_above_range,
  input wire logic i_msb_invert,
  input wire logic i_lsb_invert,
  input wire logic i_shift_clock,
  input wire logic i_parallel_load_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_serial_out,
  output logic o_underflow_flag,
  output logic o_overflow_flag,
  output logic o_sample_window,
  output logic o_irq
);
  import asp_pkg::*;

  // Formats a raw code per the two invert controls
  function automatic logic [RESULT_W-1:0] fmt_code(input logic [RESULT_W-1:0] raw,
                                                   input logic msb_invert, input logic lsb_invert);
    fmt_code = {raw[MSB_POS] ^ msb_invert, raw[MSB_POS-1:0] ^ {MSB_POS{lsb_invert}}};
  endfunction

  // Edges of a synchronised level against its previous sample
  function automatic logic rise_of(input logic prev, input logic cur);
    rise_of = ~prev & cur;
  endfunction

  function automatic logic fall_of(input logic prev, input logic cur);
    fall_of = prev & ~cur;
  endfunction

  // Synchronisers for pin inputs
  logic [1:0] conv_sync_ff;
  logic [1:0] track_sync_ff;
  logic [1:0] sclk_sync_ff;
  logic [1:0] load_sync_ff;
  logic [1:0] msb_invert_sync_ff;
  logic [1:0] lsb_invert_sync_ff;
  logic conv_prev_ff;
  logic sclk_prev_ff;
  logic load_prev_ff;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      conv_sync_ff <= 2'h0;
      track_sync_ff <= 2'h0;
      sclk_sync_ff <= 2'h0;
      load_sync_ff <= 2'h3;
      msb_invert_sync_ff <= 2'h0;
      lsb_invert_sync_ff <= 2'h0;
      conv_prev_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      load_prev_ff <= 1'b1;
    end else begin
      conv_sync_ff <= {conv_sync_ff[0], i_conv_clk};
      track_sync_ff <= {track_sync_ff[0], i_track_hold};
      sclk_sync_ff <= {sclk_sync_ff[0], i_shift_clock};
      load_sync_ff <= {load_sync_ff[0], i_parallel_load_n};
      // Pins with pull-downs: an open input settles low
      msb_invert_sync_ff <= {msb_invert_sync_ff[0], i_msb_invert};
      lsb_invert_sync_ff <= {lsb_invert_sync_ff[0], i_lsb_invert};
      conv_prev_ff <= conv_sync_ff[1];
      sclk_prev_ff <= sclk_sync_ff[1];
      load_prev_ff <= load_sync_ff[1];
    end
  end

  logic conv_fall;
  logic sclk_rise;
  logic load_active;
  logic load_end;
  assign conv_fall = fall_of(conv_prev_ff, conv_sync_ff[1]);
  assign sclk_rise = rise_of(sclk_prev_ff, sclk_sync_ff[1]);
  assign load_active = ~load_sync_ff[1];
  assign load_end = rise_of(load_prev_ff, load_sync_ff[1]);

  // Output latch: capture at converter clock fall with current format
  logic [RESULT_W-1:0] result_ff, nxt_result;
  logic under_ff, nxt_under;
  logic over_ff, nxt_over;
  logic window_ff, nxt_window;

  always_comb begin
    nxt_result = result_ff;
    nxt_under = under_ff;
    nxt_over = over_ff;
    nxt_window = track_sync_ff[1];
    if (conv_fall) begin
      if (i_below_range) begin
        // Negative full scale is raw zero, formatted
        nxt_result = fmt_code(RESULT_RESET, msb_invert_sync_ff[1], lsb_invert_sync_ff[1]);
      end else begin
        nxt_result = fmt_code(i_raw_result, msb_invert_sync_ff[1], lsb_invert_sync_ff[1]);
      end
      nxt_under = i_below_range;
      nxt_over = i_above_range;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_ff <= RESULT_RESET;
      under_ff <= 1'b0;
      over_ff <= 1'b0;
      window_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
      under_ff <= nxt_under;
      over_ff <= nxt_over;
      window_ff <= nxt_window;
    end
  end

  // Shift register and state
  asp_state_type state_ff, nxt_state;
  logic [RESULT_W-1:0] shreg_ff, nxt_shreg;
  logic [3:0] count_ff, nxt_count;

  always_comb begin
    nxt_state = state_ff;
    nxt_shreg = shreg_ff;
    nxt_count = count_ff;
    if (load_active) begin
      nxt_state = ST_LOAD;
      nxt_shreg = result_ff;
      nxt_count = 4'h1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        ST_LOAD: begin
          nxt_state = ST_SHIFT;
        end
        ST_SHIFT: begin
          if (sclk_rise) begin
            nxt_shreg = {shreg_ff[RESULT_W-2:0], 1'b0};
            nxt_count = count_ff + 4'h1;
            if (count_ff == BIT_COUNT_LAST - 4'h1) begin
              nxt_state = ST_EMPTY;
            end
          end
        end
        default: begin
          nxt_state = ST_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
      shreg_ff <= RESULT_RESET;
      count_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      shreg_ff <= nxt_shreg;
      count_ff <= nxt_count;
    end
  end

  // Serial output and flags registered
  logic sdo_ff, nxt_sdo;
  assign nxt_sdo = nxt_shreg[MSB_POS];
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sdo_ff <= 1'b0;
    end else begin
      sdo_ff <= nxt_sdo;
    end
  end

  // Control (stored for software only) and interrupts
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [2:0] irq_st_ff, nxt_irq_st;
  logic [2:0] irq_en_ff, nxt_irq_en;
  logic [31:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic [2:0] events;
  logic done_evt;
  assign done_evt = (state_ff == ST_SHIFT) && (nxt_state == ST_EMPTY);
  assign events = {conv_fall & i_below_range, done_evt, load_end};

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_irq_en = irq_en_ff;
    nxt_irq_st = irq_st_ff;
    nxt_rdata = READ_ZERO;
    if (i_wr && i_addr == ADDR_IRQ_CLEAR) begin
      nxt_irq_st = irq_st_ff & ~i_wdata[2:0];
    end
    nxt_irq_st = nxt_irq_st | events;
    if (i_wr) begin
      if (i_addr == ADDR_CTRL) begin
        nxt_ctrl = i_wdata[1:0];
      end else if (i_addr == ADDR_IRQ_ENABLE) begin
        nxt_irq_en = i_wdata[2:0];
      end
    end
    if (i_rd) begin
      if (i_addr == ADDR_CTRL) begin
        nxt_rdata = {30'h0, ctrl_ff};
      end else if (i_addr == ADDR_STATUS) begin
        nxt_rdata = {24'h0, count_ff, state_ff, over_ff, under_ff};
      end else if (i_addr == ADDR_IRQ_STATUS) begin
        nxt_rdata = {29'h0, irq_st_ff};
      end else if (i_addr == ADDR_IRQ_ENABLE) begin
        nxt_rdata = {29'h0, irq_en_ff};
      end else if (i_addr == ADDR_RESULT) begin
        nxt_rdata = {20'h0, result_ff};
      end
    end
    nxt_irq = |(nxt_irq_st & nxt_irq_en);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= CTRL_RESET;
      irq_st_ff <= IRQ_RESET;
      irq_en_ff <= IRQ_RESET;
      rdata_ff <= READ_ZERO;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      irq_st_ff <= nxt_irq_st;
      irq_en_ff <= nxt_irq_en;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_serial_out = sdo_ff;
  assign o_underflow_flag = under_ff;
  assign o_overflow_flag = over_ff;
  assign o_sample_window = window_ff;
  assign o_irq = irq_ff;

  chk_load_copies: assert property (@(posedge i_clk) disable iff (i_reset)
    load_active |=> shreg_ff == $past(result_ff)) else $error("load did not copy result");
  chk_load_blocks_shift: assert property (@(posedge i_clk) disable iff (i_reset)
    load_active && sclk_rise |=> count_ff == 4'h1) else $error("shift during load");
  chk_shift_advance: assert property (@(posedge i_clk) disable iff (i_reset)
    state_ff == ST_SHIFT && !load_active && sclk_rise
    |=> shreg_ff == {$past(shreg_ff[RESULT_W-2:0]), 1'b0}) else $error("no advance");
  chk_msb_first: assert property (@(posedge i_clk) disable iff (i_reset)
    load_active |=> o_serial_out == $past(result_ff[MSB_POS])) else $error("msb not first");
  chk_under_code: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_fall && i_below_range |=> o_underflow_flag
    && result_ff == {$past(msb_invert_sync_ff[1]), {MSB_POS{$past(lsb_invert_sync_ff[1])}}})
    else $error("bad underflow");
  chk_under_low: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_fall && !i_below_range |=> !o_underflow_flag) else $error("underflow in range");
  chk_format_map: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_fall && !i_below_range |=> result_ff == ($past(i_raw_result)
    ^ {$past(msb_invert_sync_ff[1]), {MSB_POS{$past(lsb_invert_sync_ff[1])}}})) else $error("bad format");
  chk_window_follow: assert property (@(posedge i_clk) disable iff (i_reset)
    track_sync_ff[1] |=> o_sample_window) else $error("window not high");
  chk_twelve_bits: assert property (@(posedge i_clk) disable iff (i_reset)
    state_ff == ST_SHIFT |-> count_ff <= BIT_COUNT_LAST) else $error("count overrun");
  chk_irq_level: assert property (@(posedge i_clk) disable iff (i_reset)
    o_irq == |(irq_st_ff & irq_en_ff)) else $error("irq level mismatch");

  // Flags and window
  chk_window_low: assert property (@(posedge i_clk) disable iff (i_reset)
    !track_sync_ff[1] |=> !o_sample_window) else $error("window not low");
  chk_over_follow: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_fall |=> o_overflow_flag == $past(i_above_range)) else $error("bad overflow");
  chk_under_follow: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_fall |=> o_underflow_flag == $past(i_below_range)) else $error("bad underflow flag");
  chk_flags_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    !conv_fall |=> $stable(o_underflow_flag) && $stable(o_overflow_flag))
    else $error("flags moved");

  // Shift register
  chk_load_count: assert property (@(posedge i_clk) disable iff (i_reset)
    load_active |=> count_ff == 4'h1 && state_ff == ST_LOAD) else $error("load state bad");
  chk_empty_stays: assert property (@(posedge i_clk) disable iff (i_reset)
    state_ff == ST_EMPTY && !load_active |=> state_ff == ST_EMPTY) else $error("left empty");
  chk_sdo_msb: assert property (@(posedge i_clk) disable iff (i_reset)
    state_ff == ST_SHIFT |-> o_serial_out == shreg_ff[MSB_POS]) else $error("sdo not msb");
  chk_no_shift_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    state_ff != ST_SHIFT && !load_active |=> shreg_ff == $past(shreg_ff))
    else $error("shift outside frame");
  chk_count_step: assert property (@(posedge i_clk) disable iff (i_reset)
    state_ff == ST_SHIFT && !load_active && sclk_rise
    |=> count_ff == $past(count_ff) + 4'h1) else $error("count step bad");

  // Register port
  chk_rdata_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_rd |=> o_rdata == READ_ZERO) else $error("read data not idle");
  chk_rdata_result: assert property (@(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == ADDR_RESULT |=> o_rdata == {20'h0, $past(result_ff)})
    else $error("bad result read");
  chk_rdata_irq: assert property (@(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == ADDR_IRQ_STATUS |=> o_rdata == {29'h0, $past(irq_st_ff)})
    else $error("bad status read");
  chk_ctrl_write: assert property (@(posedge i_clk) disable iff (i_reset)
    i_wr && i_addr == ADDR_CTRL |=> ctrl_ff == $past(i_wdata[1:0])) else $error("ctrl write");
  chk_en_write: assert property (@(posedge i_clk) disable iff (i_reset)
    i_wr && i_addr == ADDR_IRQ_ENABLE |=> irq_en_ff == $past(i_wdata[2:0]))
    else $error("enable write");

  // Interrupt status
  chk_clear_bits: assert property (@(posedge i_clk) disable iff (i_reset)
    i_wr && i_addr == ADDR_IRQ_CLEAR && events == 3'h0
    |=> irq_st_ff == ($past(irq_st_ff) & ~$past(i_wdata[2:0]))) else $error("clear failed");
  chk_set_wins: assert property (@(posedge i_clk) disable iff (i_reset)
    |events |=> (irq_st_ff & $past(events)) == $past(events)) else $error("event lost");
  chk_load_event: assert property (@(posedge i_clk) disable iff (i_reset)
    load_end |=> irq_st_ff[IRQ_LOAD_POS]) else $error("load event missing");
  chk_done_event: assert property (@(posedge i_clk) disable iff (i_reset)
    done_evt |=> irq_st_ff[IRQ_DONE_POS]) else $error("done event missing");
  chk_under_event: assert property (@(posedge i_clk) disable iff (i_reset)
    conv_fall && i_below_range |=> irq_st_ff[IRQ_UNDER_POS]) else $error("under event missing");

  cov_load: cover property (@(posedge i_clk) disable iff (i_reset) load_end);
  cov_shift: cover property (@(posedge i_clk) disable iff (i_reset) state_ff == ST_SHIFT && sclk_rise);
  cov_irq: cover property (@(posedge i_clk) disable iff (i_reset) o_irq);
  cov_done: cover property (@(posedge i_clk) disable iff (i_reset) done_evt);
  cov_under: cover property (@(posedge i_clk) disable iff (i_reset) conv_fall && i_below_range);
endmodule

// [asp_serial_port_tb.sv]
// Bench for the converter serial output port, host model on the serial side.
// Assumes a 50 MHz system clock; the shift clock comes from the host model.
`timescale 1ns/10ps
module asp_serial_port_tb;
  import asp_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic conv_clk = 1'b0, track = 1'b0, below = 1'b0, msb_invert = 1'b0, lsb_invert = 1'b0;
  logic wr = 1'b0, rd = 1'b0, start = 1'b0, noisy = 1'b0, above = 1'b0;
  logic [11:0] raw = 12'h000;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic sout, uflag, oflag, swin, irq, shclk, load_n, done;
  logic [11:0] word;
  int failures = 0;
  int n_tests = 0;
  always #10 i_clk = ~i_clk;
  asp_serial_port u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_conv_clk(conv_clk),
    .i_track_hold(track), .i_raw_result(raw), .i_below_range(below),
    .i_above_range(above), .i_msb_invert(msb_invert), .i_lsb_invert(lsb_invert),
    .i_shift_clock(shclk), .i_parallel_load_n(load_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_serial_out(sout), .o_underflow_flag(uflag),
    .o_overflow_flag(oflag), .o_sample_window(swin), .o_irq(irq));
  asp_host_model u_host (.i_clk(i_clk), .i_start(start), .i_noisy(noisy),
    .i_serial_out(sout), .o_shift_clock(shclk), .o_parallel_load_n(load_n),
    .o_word(word), .o_done(done));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge i_clk);
  endtask
  task automatic convert(input logic [11:0] r, input logic b);
    raw <= r;
    below <= b;
    conv_clk <= 1'b1;
    tick(4);
    conv_clk <= 1'b0;
    tick(8);
  endtask
  task automatic frame(input logic nz);
    int k;
    start <= 1'b1;
    noisy <= nz;
    @(posedge i_clk);
    start <= 1'b0;
    for (k = 0; k < 400; k++) begin
      @(posedge i_clk);
      #1;
      if (done === 1'b1) break;
    end
    if (k == 400) begin
      failures++;
      $display("ERROR %0t: frame never finished", $time);
      test_done();
    end
  endtask
  task automatic t_window();
    track <= 1'b1;
    tick(6);
    check(swin, 1'b1);
    track <= 1'b0;
    tick(6);
    check(swin, 1'b0);
    $display("window test done");
  endtask
  task automatic t_format();
    for (int f = 0; f < 4; f++) begin
      msb_invert <= f[1];
      lsb_invert <= f[0];
      tick(4);
      convert(12'ha5c, 1'b0);
      frame(1'b0);
      check({20'h0, word}, {20'h0, 12'ha5c ^ {f[1], {11{f[0]}}}});
      check(uflag, 1'b0);
    end
    $display("format test done");
  endtask
  task automatic t_under();
    msb_invert <= 1'b1;
    lsb_invert <= 1'b0;
    tick(4);
    convert(12'h7ff, 1'b1);
    frame(1'b1);
    check({20'h0, word}, 32'h800);
    check(uflag, 1'b1);
    msb_invert <= 1'b0;
    tick(4);
    $display("underflow test done");
  endtask
  task automatic t_over();
    msb_invert <= 1'b1;
    above <= 1'b1;
    tick(4);
    convert(12'hfff, 1'b0);
    check(oflag, 1'b1);
    check(uflag, 1'b0);
    above <= 1'b0;
    msb_invert <= 1'b0;
    tick(4);
    convert(12'h000, 1'b0);
    check(oflag, 1'b0);
    $display("overflow test done");
  endtask
  task automatic t_irq();
    convert(12'h123, 1'b0);
    wr_reg(ADDR_IRQ_CLEAR, 32'h7);
    wr_reg(ADDR_IRQ_ENABLE, 32'h0);
    frame(1'b0);
    check({20'h0, word}, 32'h123);
    tick(3);
    check(irq, 1'b0);
    rd_reg(ADDR_IRQ_STATUS);
    check(d & 32'h3, 32'h3);
    rd_reg(ADDR_RESULT);
    check(d, 32'h123);
    rd_reg(ADDR_STATUS);
    check(d, {24'h0, BIT_COUNT_LAST, ST_EMPTY, 2'b00});
    wr_reg(ADDR_CTRL, 32'h3);
    rd_reg(ADDR_CTRL);
    check(d, 32'h3);
    wr_reg(ADDR_CTRL, 32'h0);
    wr_reg(ADDR_IRQ_ENABLE, 32'h7);
    tick(2);
    check(irq, 1'b1);
    wr_reg(ADDR_IRQ_CLEAR, 32'h7);
    tick(2);
    check(irq, 1'b0);
    rd_reg(4'hf);
    check(d, READ_ZERO);
    $display("interrupt test done");
  endtask
  initial begin
    tick(10);
    i_reset <= 1'b0;
    tick(2);
    t_window();
    t_format();
    t_under();
    t_over();
    t_irq();
    test_done();
  end
endmodule
